// [sri_map.svh]
// Address map, reset values and timing counts of the reset initializer.
// Included by the design and the testbench; holds definitions only.
`ifndef SRI_MAP_SVH
`define SRI_MAP_SVH

// ----------------------------------------------------------------------
// Vector locations and special register addresses
// ----------------------------------------------------------------------
`define SRI_VEC_LOW_ADDR   16'hFFFC
`define SRI_VEC_HIGH_ADDR  16'hFFFD
`define SRI_WDT_CTRL_ADDR  16'h0037
`define SRI_CLK_CTRL_ADDR  16'h0FFC
`define SRI_WDT_PRESET     8'hFF
`define SRI_WDT_CTRL_RST   8'h3F
`define SRI_CLK_CTRL_RST   8'h00
`define SRI_ZERO_BYTE      8'h00

// ----------------------------------------------------------------------
// Fields of the watchdog and clock control words
// ----------------------------------------------------------------------
`define SRI_WDT_SRC_BIT    7
`define SRI_WDT_STPDIS_BIT 6
`define SRI_CLK_SUBEN_BIT  2
`define SRI_CLK_DIV_MSB    1

// ----------------------------------------------------------------------
// Initialized register table: entry 0 is the leftmost
// ----------------------------------------------------------------------
`define SRI_NREG 59
`define SRI_ADDR_TABLE { \
    16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, \
    16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h000D, 16'h0018, 16'h0019, \
    16'h001D, 16'h001F, 16'h0020, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h0025, \
    16'h0026, 16'h0028, 16'h0029, 16'h002A, 16'h002B, 16'h002C, 16'h002D, 16'h002E, \
    16'h002F, 16'h0030, 16'h0038, 16'h0039, 16'h003A, 16'h003B, 16'h003C, 16'h003D, \
    16'h003E, 16'h003F, 16'h0FE0, 16'h0FE1, 16'h0FE3, 16'h0FE4, 16'h0FF0, 16'h0FF1, \
    16'h0FF2, 16'h0FF3, 16'h0FF4, 16'h0FF5, 16'h0FF6, 16'h0FF7, 16'h0FF8, 16'h0FF9, \
    16'h0FFA, 16'h0FFB, 16'h0FFE}
`define SRI_RESET_TABLE { \
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
    8'h00, 8'h00, 8'h00, 8'h08, 8'h80, 8'h80, 8'hFF, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, \
    8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, \
    8'h00, 8'h48, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'hE0, 8'h00, 8'h00, \
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h01}

// Table indices of registers that are checked by name
`define SRI_IDX_PORT0      0
`define SRI_IDX_PORT6_DIR  13
`define SRI_IDX_ADC_CTRL   15
`define SRI_IDX_SER1_STAT  16
`define SRI_IDX_TMRX_LOW   27
`define SRI_IDX_TMRX_EXT   29
`define SRI_IDX_CPU_MODE   37
`define SRI_IDX_IRQ_REQ1   38
`define SRI_IDX_UART1_CTRL 43
`define SRI_IDX_SEG_DIS0   54
`define SRI_IDX_NVM_CTRL   58

// Values that assertions compare against
`define SRI_ADC_CTRL_RST   8'h08
`define SRI_SER_STAT_RST   8'h80
`define SRI_UART_CTRL_RST  8'hE0
`define SRI_TMR_RST        8'hFF
`define SRI_SEG_DIS_RST    8'hFF
`define SRI_CPU_MODE_RST   8'h48
`define SRI_NVM_CTRL_RST   8'h01

`endif

// [sri_pkg.sv]
// Types shared by the reset initializer and its surroundings.
// Assumes sri_map.svh is on the include path.
package sri_pkg;

    // Register bus request from the CPU side
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } sri_bus_s;

    // Reset sequencer states
    typedef enum logic [3:0] {
        ST_HOLD   = 4'b0001,
        ST_FETCHL = 4'b0010,
        ST_FETCHH = 4'b0100,
        ST_RUN    = 4'b1000
    } sri_state_e;

    // System clock divider selection
    typedef enum logic [1:0] {
        DIV_8   = 2'b00,
        DIV_4   = 2'b01,
        DIV_2   = 2'b10,
        DIV_LOW = 2'b11
    } sri_div_e;

endpackage

// [sri_reset_init.sv]
// System reset initializer: reset sources, register reset values,
// watchdog, clock state at power-on and reset vector fetch.
// Assumes a synchronous memory port answering vecData one cycle after vecRd.
//
// Notes on behaviour
// - After reset, PC loads high byte from FFFD, low byte from FFFC.
// - Watchdog keeps counting in stop-wakeup wait and wait mode.
// - Port data and direction registers of ports 0..6 reset to 00.
// - Watchdog control register reads 00111111 after reset.
// - Processor mode register at 003B resets to 01001000.
// - Converter control register resets to 08.
// - Serial status registers reset with only bit 7 set.
// - Asynchronous serial control registers reset to 11100000.
// - Timers X and Y bytes reset to FF, timer X extension to 00.
// - Segment output disable registers 0FF8..0FFA reset to FF.
// - Nonvolatile memory control resets bits 4..1 clear, bit 0 set.
// - Interrupt, edge, display, clock output and timer mode registers reset to 00.
// - Unlisted registers and RAM are not initialized by reset.
// - After power-on only main oscillator runs; sub-clock pins act as ports.
// - After reset release the system clock is main oscillator divided by 8.
// - Watchdog underflow raises internal reset with same initialization and fetch.
// - Watchdog stopped and preset to FF at reset, runs after first write.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "sri_map.svh"

module sri_reset_init #(
    parameter int WDT_DIV      = 16,   // System clocks per watchdog count
    parameter int RELEASE_CLKS = 16    // Internal reset hold after underflow
) (
    input  wire logic             sys_clk,      // System clock, 25 MHz
    input  wire logic             rst,          // Power-on reset, sync, active high
    input  wire logic             resetPin_n,   // External reset pin, active low
    input  wire sri_pkg::sri_bus_s bus,         // Register bus request
    output logic [7:0]            rdata,        // Read data, cycle after read
    input  wire logic             waitMode,     // Core in wait mode
    input  wire logic             stopWake,     // Oscillator stabilisation wait
    input  wire logic             stopInstr,    // Stop instruction executed, pulse
    output logic                  vecRd,        // Vector read strobe
    output logic [15:0]           vecAddr,      // Vector read address
    input  wire logic [7:0]       vecData,      // Vector byte, cycle after vecRd
    output logic [15:0]           pcValue,      // Loaded program counter
    output logic                  cpuRun,       // Instruction fetch allowed
    output sri_pkg::sri_div_e     clkDiv,       // System clock divider selection
    output logic                  subOscRun,    // Sub-clock oscillator enabled
    output logic                  subPinsPort   // Sub-clock pins act as port pins
);

    // ------------------------------------------------------------------
    // Tables and declarations
    // ------------------------------------------------------------------
    localparam int N = `SRI_NREG;
    localparam logic [16*N-1:0] ADDR_T = `SRI_ADDR_TABLE;
    localparam logic [8*N-1:0]  RST_T  = `SRI_RESET_TABLE;
    localparam int DW = $clog2(WDT_DIV + 1);
    localparam int RW = $clog2(RELEASE_CLKS + 1);
    // Reset words held as constants so that single fields can be picked out
    localparam logic [7:0] WDT_CTRL_RST = `SRI_WDT_CTRL_RST;
    localparam logic [7:0] NVM_CTRL_RST = `SRI_NVM_CTRL_RST;

    sri_pkg::sri_state_e stateReg;
    logic [7:0]          regArr [N];
    logic                pinSync1Reg;
    logic                pinSync2Reg;
    logic                anyReset;
    logic                running;
    logic [7:0]          wdtCountReg;
    logic                wdtStartedReg;
    logic                wdtSrcReg;
    logic                wdtStpDisReg;
    logic [DW-1:0]       wdtDivReg;
    logic                wdtTick;
    logic                wdtUnder;
    logic                wdtWrite;
    logic [RW-1:0]       releaseCntReg;
    logic                releaseBusy;
    logic [7:0]          clkCtrlReg;
    logic [7:0]          vecLowReg;
    logic [7:0]          readMux;

    // ------------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------------
    // Two-stage synchronizer on the external pin
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinSync1Reg <= 1'b0;
            pinSync2Reg <= 1'b0;
        end else begin
            pinSync1Reg <= resetPin_n;
            pinSync2Reg <= pinSync1Reg;
        end
    end

    // Internal reset from watchdog underflow or a disabled stop instruction
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            releaseCntReg <= '0;
        end else if (wdtUnder || (stopInstr && wdtStpDisReg && running)) begin
            releaseCntReg <= RW'(RELEASE_CLKS);
        end else if (releaseCntReg != '0) begin
            releaseCntReg <= releaseCntReg - 1'b1;
        end
    end

    assign releaseBusy = (releaseCntReg != '0);
    assign anyReset    = rst || !pinSync2Reg || releaseBusy;
    assign running     = (stateReg == sri_pkg::ST_RUN);

    // ------------------------------------------------------------------
    // Reset sequencer and vector fetch
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            stateReg <= sri_pkg::ST_HOLD;
        end else begin
            unique case (stateReg)
                sri_pkg::ST_HOLD:   stateReg <= sri_pkg::ST_FETCHL;
                sri_pkg::ST_FETCHL: stateReg <= sri_pkg::ST_FETCHH;
                sri_pkg::ST_FETCHH: stateReg <= sri_pkg::ST_RUN;
                sri_pkg::ST_RUN:    stateReg <= sri_pkg::ST_RUN;
                default:            stateReg <= sri_pkg::ST_HOLD;
            endcase
        end
    end

    // Vector read request: low byte first, then high byte
    always_comb begin
        vecRd   = !anyReset && (stateReg == sri_pkg::ST_HOLD || stateReg == sri_pkg::ST_FETCHL);
        vecAddr = (stateReg == sri_pkg::ST_FETCHL) ? `SRI_VEC_HIGH_ADDR
                                                   : `SRI_VEC_LOW_ADDR;
    end

    // Program counter assembly
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vecLowReg <= `SRI_ZERO_BYTE;
            pcValue   <= '0;
        end else if (!anyReset && stateReg == sri_pkg::ST_FETCHL) begin
            vecLowReg <= vecData;
        end else if (!anyReset && stateReg == sri_pkg::ST_FETCHH) begin
            pcValue   <= {vecData, vecLowReg};
        end
    end

    assign cpuRun = running;

    // ------------------------------------------------------------------
    // Initialized registers
    // ------------------------------------------------------------------
    // Unlisted addresses other than 0037 and 0FFC have no storage here and read as zero
    generate
        for (genvar i = 0; i < N; i++) begin : g_reg
            always_ff @(posedge sys_clk) begin
                if (anyReset) begin
                    regArr[i] <= RST_T[8*(N-1-i) +: 8];
                end else if (running && bus.wr && bus.addr == ADDR_T[16*(N-1-i) +: 16]) begin
                    regArr[i] <= bus.wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    assign wdtWrite = running && bus.wr && bus.addr == `SRI_WDT_CTRL_ADDR;
    assign wdtTick  = (wdtDivReg == DW'(WDT_DIV - 1));
    assign wdtUnder = wdtStartedReg && wdtTick && (wdtCountReg == 8'h00);

    // Count source prescaler; gated by neither waitMode nor stopWake
    always_ff @(posedge sys_clk) begin
        if (anyReset || wdtTick) begin
            wdtDivReg <= '0;
        end else begin
            wdtDivReg <= wdtDivReg + 1'b1;
        end
    end

    // Counter: stopped and preset until the first control write
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            wdtCountReg   <= `SRI_WDT_PRESET;
            wdtStartedReg <= 1'b0;
        end else if (wdtWrite) begin
            wdtCountReg   <= `SRI_WDT_PRESET;
            wdtStartedReg <= 1'b1;
        end else if (wdtStartedReg && wdtTick) begin
            wdtCountReg   <= wdtCountReg - 1'b1;
        end
    end

    // Control bits: stop-disable can be set but never cleared by software
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            wdtSrcReg    <= WDT_CTRL_RST[`SRI_WDT_SRC_BIT];
            wdtStpDisReg <= WDT_CTRL_RST[`SRI_WDT_STPDIS_BIT];
        end else if (wdtWrite) begin
            wdtSrcReg    <= bus.wdata[`SRI_WDT_SRC_BIT];
            wdtStpDisReg <= wdtStpDisReg | bus.wdata[`SRI_WDT_STPDIS_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Clock source state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (anyReset) begin
            clkCtrlReg <= `SRI_CLK_CTRL_RST;
        end else if (running && bus.wr && bus.addr == `SRI_CLK_CTRL_ADDR) begin
            clkCtrlReg <= bus.wdata;
        end
    end

    assign clkDiv      = sri_pkg::sri_div_e'(clkCtrlReg[`SRI_CLK_DIV_MSB:0]);
    assign subOscRun   = clkCtrlReg[`SRI_CLK_SUBEN_BIT];
    assign subPinsPort = !clkCtrlReg[`SRI_CLK_SUBEN_BIT];

    // ------------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------------
    always_comb begin
        readMux = `SRI_ZERO_BYTE;
        for (int j = 0; j < N; j++) begin
            if (bus.addr == ADDR_T[16*(N-1-j) +: 16]) begin
                readMux = regArr[j];
            end
        end
        if (bus.addr == `SRI_WDT_CTRL_ADDR) begin
            readMux = {wdtSrcReg, wdtStpDisReg, wdtCountReg[7:2]};
        end
        if (bus.addr == `SRI_CLK_CTRL_ADDR) begin
            readMux = clkCtrlReg;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst || !bus.rd) begin
            rdata <= `SRI_ZERO_BYTE;
        end else begin
            rdata <= readMux;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_release;
        (stateReg == sri_pkg::ST_HOLD) && !anyReset;
    endsequence
    sequence s_fetch_done;
        vecRd && vecAddr == `SRI_VEC_LOW_ADDR ##1 vecRd && vecAddr == `SRI_VEC_HIGH_ADDR ##1 cpuRun == 1'b0;
    endsequence

    a_vector_order: assert property (s_release |-> s_fetch_done)
        else $error("vector fetch order wrong");
    a_pc_load: assert property (stateReg == sri_pkg::ST_FETCHH && !anyReset
        |=> cpuRun && pcValue == {$past(vecData), $past(vecData, 2)})
        else $error("program counter not loaded from vector");
    a_hold_no_fetch: assert property (anyReset |-> !vecRd ##1 !cpuRun)
        else $error("fetch during reset");
    a_pin_sync: assert property (!resetPin_n |-> ##3 stateReg == sri_pkg::ST_HOLD)
        else $error("pin reset not taken");
    a_port_reset: assert property (anyReset |=>
        regArr[`SRI_IDX_PORT0] == 8'h00
        && regArr[`SRI_IDX_PORT6_DIR] == 8'h00 && regArr[`SRI_IDX_IRQ_REQ1] == 8'h00)
        else $error("port or interrupt reset value wrong");
    a_mode_reset: assert property (anyReset |=>
        regArr[`SRI_IDX_CPU_MODE] == `SRI_CPU_MODE_RST
        && regArr[`SRI_IDX_ADC_CTRL] == `SRI_ADC_CTRL_RST)
        else $error("mode or converter reset value wrong");
    a_serial_reset: assert property (anyReset |=>
        regArr[`SRI_IDX_SER1_STAT] == `SRI_SER_STAT_RST
        && regArr[`SRI_IDX_UART1_CTRL] == `SRI_UART_CTRL_RST)
        else $error("serial reset value wrong");
    a_timer_reset: assert property (anyReset |=>
        regArr[`SRI_IDX_TMRX_LOW] == `SRI_TMR_RST && regArr[`SRI_IDX_TMRX_EXT] == 8'h00
        && regArr[`SRI_IDX_SEG_DIS0] == `SRI_SEG_DIS_RST
        && regArr[`SRI_IDX_NVM_CTRL][4:0] == NVM_CTRL_RST[4:0])
        else $error("timer, segment or memory reset value wrong");
    a_seg_reset: assert property (anyReset |=>
        regArr[`SRI_IDX_SEG_DIS0 + 1] == `SRI_SEG_DIS_RST
        && regArr[`SRI_IDX_SEG_DIS0 + 2] == `SRI_SEG_DIS_RST)
        else $error("segment disable reset value wrong");
    a_wdt_readback: assert property (stateReg == sri_pkg::ST_FETCHL
        |-> {wdtSrcReg, wdtStpDisReg, wdtCountReg[7:2]} == WDT_CTRL_RST)
        else $error("watchdog control reset pattern wrong");
    a_wdt_stopped: assert property (!wdtStartedReg && !wdtWrite |=> wdtCountReg == `SRI_WDT_PRESET)
        else $error("watchdog counted before first write");
    a_wdt_in_wait: assert property ((waitMode || stopWake) && wdtStartedReg && wdtTick
        && wdtCountReg != 8'h00 && !wdtWrite && !anyReset
        |=> wdtCountReg == $past(wdtCountReg) - 8'h01)
        else $error("watchdog halted in wait");
    a_wdt_reset: assert property (wdtUnder
        |=> releaseBusy ##1 stateReg == sri_pkg::ST_HOLD)
        else $error("underflow did not reset");
    a_stop_reset: assert property (stopInstr && wdtStpDisReg && running
        |=> releaseBusy ##1 stateReg == sri_pkg::ST_HOLD)
        else $error("disabled stop did not reset");
    a_clock_default: assert property (stateReg == sri_pkg::ST_FETCHL
        |-> clkDiv == sri_pkg::DIV_8 && !subOscRun && subPinsPort)
        else $error("clock state after reset wrong");

endmodule // sri_reset_init

// [sri_reset_source.sv]
// Model of the external reset circuit that drives the reset pin.
// Assumes the bench pulses pulseReq for one clock per reset request.
`timescale 1ns/1ns

module sri_reset_source #(
    parameter int LOW_CLKS = 50    // Pin low time in clocks, 2 us at 25 MHz
) (
    input  wire logic sys_clk,     // System clock
    input  wire logic pulseReq,    // Request one reset pulse
    output logic      resetPin_n   // Reset pin, active low
);
    // ------------------------------------------------------------------
    // Pulse timer
    // ------------------------------------------------------------------
    int lowCnt_reg = 0;

    // Holds the pin low for the full minimum time, then lets it go high
    always_ff @(posedge sys_clk) begin
        if (pulseReq) begin
            lowCnt_reg <= LOW_CLKS;
        end else if (lowCnt_reg > 0) begin
            lowCnt_reg <= lowCnt_reg - 1;
        end
    end

    // Pin is pulled high whenever the circuit is not holding it
    assign resetPin_n = (lowCnt_reg == 0);
endmodule // sri_reset_source

// [system_reset_initializer_tb.sv]
// Self-checking bench for the reset initializer.
// Assumes sri_pkg and sri_map.svh; a small vector memory lives here.
`timescale 1ns/1ns
`include "sri_map.svh"

module system_reset_initializer_tb;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    localparam logic [16*`SRI_NREG-1:0] ADDRS = `SRI_ADDR_TABLE;
    localparam logic [8*`SRI_NREG-1:0]  VALS  = `SRI_RESET_TABLE;
    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic              pulseReq = 1'b0;
    logic              resetPin_n;
    sri_pkg::sri_bus_s bus = '0;
    logic [7:0]        rdata;
    logic              waitMode = 1'b0;
    logic              stopWake = 1'b0;
    logic              stopInstr = 1'b0;
    logic [7:0]        vecHigh = 8'h12;
    logic              vecRd;
    logic [15:0]       vecAddr;
    logic [7:0]        vecData = 8'h00;
    logic [15:0]       pcValue;
    logic              cpuRun;
    sri_pkg::sri_div_e clkDiv;
    logic              subOscRun;
    logic              subPinsPort;
    int                badCount = 0;
    int                comparisons = 0;

    sri_reset_init #(.WDT_DIV(2), .RELEASE_CLKS(2)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .resetPin_n(resetPin_n), .bus(bus),
        .rdata(rdata), .waitMode(waitMode), .stopWake(stopWake),
        .stopInstr(stopInstr), .vecRd(vecRd), .vecAddr(vecAddr), .vecData(vecData),
        .pcValue(pcValue), .cpuRun(cpuRun), .clkDiv(clkDiv),
        .subOscRun(subOscRun), .subPinsPort(subPinsPort));

    sri_reset_source u_pin (.sys_clk(sys_clk), .pulseReq(pulseReq), .resetPin_n(resetPin_n));

    // Clock of 40 ns period
    always #20 sys_clk = ~sys_clk;

    // Vector memory with one cycle latency; toggles when not read
    always_ff @(posedge sys_clk) begin
        if (vecRd) begin
            vecData <= (vecAddr == 16'hFFFC) ? 8'h34 : (vecAddr == 16'hFFFD) ? vecHigh : 8'hA5;
        end else begin
            vecData <= ~vecData;
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            badCount++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
    endtask

    // Read strobe for one cycle, data taken in the cycle after it
    task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, rdata});
    endtask

    // Bounded wait for the run level
    task automatic waitRun(input logic v, input int n);
        int k;
        k = 0;
        while (cpuRun !== v && k < n) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        chk("cpuRun", {15'h0, v}, {15'h0, cpuRun});
        if (cpuRun !== v) begin
            wrapUp();
        end
    endtask

    // State just after any reset has completed
    task automatic chkBoot(input logic [15:0] pc);
        chk("pcValue", pc, pcValue);
        chk("clkDiv", {14'h0, sri_pkg::DIV_8}, {14'h0, clkDiv});
        chk("subOscRun", 16'h0000, {15'h0, subOscRun});
        chk("subPinsPort", 16'h0001, {15'h0, subPinsPort});
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        // Power-on values of every listed register
        waitRun(1'b1, 20);
        chkBoot(16'h1234);
        for (int i = 0; i < `SRI_NREG; i++) begin
            rdChk(ADDRS[16*(`SRI_NREG-1-i) +: 16], VALS[8*(`SRI_NREG-1-i) +: 8]);
        end
        rdChk(16'h0037, 8'h3F);
        wr(16'h0040, 8'h5A);
        rdChk(16'h0040, 8'h00);
        $display("test power_on finished");
        // Pin reset restores registers and clock state
        wr(16'h0000, 8'hA5);
        rdChk(16'h0000, 8'hA5);
        wr(16'h0FFC, 8'h05);
        @(posedge sys_clk);
        #1;
        chk("clkDiv", {14'h0, sri_pkg::DIV_4}, {14'h0, clkDiv});
        chk("subPinsPort", 16'h0000, {15'h0, subPinsPort});
        @(posedge sys_clk);
        pulseReq <= 1'b1;
        vecHigh <= 8'h56;
        @(posedge sys_clk);
        pulseReq <= 1'b0;
        waitRun(1'b0, 5);
        wr(16'h0001, 8'h77);
        repeat (35) @(posedge sys_clk);
        #1;
        chk("cpuRun held", 16'h0000, {15'h0, cpuRun});
        waitRun(1'b1, 40);
        chkBoot(16'h5634);
        rdChk(16'h0000, 8'h00);
        rdChk(16'h0001, 8'h00);
        $display("test pin_reset finished");
        // Watchdog idle until written, then underflow resets
        repeat (600) @(posedge sys_clk);
        #1;
        chk("cpuRun idle", 16'h0001, {15'h0, cpuRun});
        @(posedge sys_clk);
        waitMode <= 1'b1;
        stopWake <= 1'b1;
        vecHigh <= 8'h78;
        wr(16'h0037, 8'h00);
        rdChk(16'h0037, 8'h3F);
        wr(16'h0000, 8'hA5);
        waitRun(1'b0, 600);
        @(posedge sys_clk);
        waitMode <= 1'b0;
        stopWake <= 1'b0;
        waitRun(1'b1, 20);
        chkBoot(16'h7834);
        rdChk(16'h0000, 8'h00);
        rdChk(16'h0037, 8'h3F);
        $display("test watchdog finished");
        // Stop instruction with stop disabled acts as an internal reset
        wr(16'h0037, 8'hC0);
        rdChk(16'h0037, 8'hFF);
        wr(16'h0037, 8'h00);
        rdChk(16'h0037, 8'h7F);
        @(posedge sys_clk);
        stopInstr <= 1'b1;
        vecHigh <= 8'h9A;
        @(posedge sys_clk);
        stopInstr <= 1'b0;
        waitRun(1'b0, 5);
        waitRun(1'b1, 20);
        chkBoot(16'h9A34);
        rdChk(16'h0037, 8'h3F);
        $display("test stop_reset finished");
        wrapUp();
    end
endmodule // system_reset_initializer_tb
